// file: bench/ctrig_seq_model.sv
// Sequencer stand-in: ends each sequence and reports STOP on the serial bus.
// Assumes the control register's outputs on the same clock.
`timescale 1ns/1ps

module ctrig_seq_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic startCmd,
    input wire logic stopAfterByte,
    input wire logic stopAtSeqEnd,
    output logic sequenceDone,
    output logic stopDetected
);
    logic [2:0] seqCnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqCnt <= 3'h0;
            sequenceDone <= 1'b0;
            stopDetected <= 1'b0;
        end else begin
            sequenceDone <= (seqCnt == 3'h1);
            seqCnt <= startCmd ? 3'h4 : (seqCnt != 3'h0 ? seqCnt - 3'h1 : 3'h0);
            // One pulse per request, so the cleared bits are not re-reported.
            // A stop at sequence end on a loop with no sequence running ends at once.
            stopDetected <= (stopAfterByte || (stopAtSeqEnd && seqCnt == 3'h0 && !startCmd))
                && !stopDetected;
        end
    end
endmodule

// file: bench/i2c_channel_trigger_control_test.sv
// Self-checking bench for the channel control register and its trigger path.
// Assumes the sequencer model in the bench folder.
`timescale 1ns/1ps

module i2c_channel_trigger_control_test;
    import ctrig_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] busAddr = 8'hC0;
    ctrig_byte_t busWrData = 8'h00;
    logic busWrite = 1'b0;
    logic busRead = 1'b0;
    logic triggerPin = 1'b0;
    ctrig_byte_t transactionSelect = 8'h00;
    ctrig_byte_t transactionOffset = 8'h00;
    logic serialBusFree = 1'b1;
    ctrig_byte_t busRdData;
    ctrig_ptr_t dataPtrValue;
    logic startCmd, busError, channelActive, stopAfterByte, stopAtSeqEnd;
    logic countPtrClear, tablePtrClear, sequenceDone, stopDetected;
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;
    int hits, first;

    ctrig_channel_control DUT (.clk(clk), .rst_n(rst_n), .busAddr(busAddr),
        .busWrData(busWrData), .busWrite(busWrite), .busRead(busRead),
        .busRdData(busRdData), .triggerPin(triggerPin),
        .transactionSelect(transactionSelect), .transactionOffset(transactionOffset),
        .serialBusFree(serialBusFree), .sequenceDone(sequenceDone),
        .stopDetected(stopDetected), .startCmd(startCmd), .busError(busError),
        .channelActive(channelActive), .stopAfterByte(stopAfterByte),
        .stopAtSeqEnd(stopAtSeqEnd), .countPtrClear(countPtrClear),
        .tablePtrClear(tablePtrClear), .dataPtrValue(dataPtrValue));
    ctrig_seq_model SEQ (.clk(clk), .rst_n(rst_n), .startCmd(startCmd),
        .stopAfterByte(stopAfterByte), .stopAtSeqEnd(stopAtSeqEnd),
        .sequenceDone(sequenceDone), .stopDetected(stopDetected));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic results();
        $display("checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_mismatch = n_mismatch + 1;
            results();
        end
    end

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // Bit 0 is always written as zero by the callers.
    task automatic wr(ctrig_byte_t d);
        @(negedge clk);
        busWrData = d;
        busWrite = 1'b1;
        @(negedge clk);
        busWrite = 1'b0;
    endtask

    task automatic rd(ctrig_byte_t exp);
        @(negedge clk);
        busRead = 1'b1;
        @(negedge clk);
        busRead = 1'b0;
        chk("read data", {8'h00, exp}, {8'h00, busRdData});
    endtask

    task automatic cmdIn(int n);
        hits = 0;
        first = 0;
        for (int k = 1; k <= n; k++) begin
            @(negedge clk);
            if (startCmd === 1'b1) begin
                hits = hits + 1;
                if (first == 0) begin
                    first = k;
                end
            end
        end
    endtask

    task automatic tPtr();
        transactionSelect = 8'h00;
        transactionOffset = 8'h3C;
        wr(8'h06);
        chk("count clear", 16'h1, {15'h0, countPtrClear});
        chk("table clear", 16'h1, {15'h0, tablePtrClear});
        chk("data pointer", 16'h003C, dataPtrValue);
        rd(8'h00);
        wr(8'hA0);
        @(negedge clk);
        chk("stop bits", 16'h0, {14'h0, stopAfterByte, stopAtSeqEnd});
    endtask

    task automatic tGateOff();
        wr(8'h40);
        chk("start pulse", 16'h1, {15'h0, startCmd});
        triggerPin = 1'b1;
        cmdIn(4);
        triggerPin = 1'b0;
        cmdIn(8);
        chk("gate off starts", 16'h0, hits[15:0]);
        chk("active", 16'h0, {15'h0, channelActive});
    endtask

    task automatic tTrigRise();
        @(negedge clk);
        triggerPin = 1'b1;
        wr(8'h48);
        cmdIn(8);
        chk("early trigger", 16'h0, hits[15:0]);
        wr(8'h54);
        chk("count clear", 16'h1, {15'h0, countPtrClear});
        rd(8'h48);
        triggerPin = 1'b0;
        @(negedge clk);
        triggerPin = 1'b1;
        cmdIn(8);
        chk("rise latency", 16'h4, first[15:0]);
        wr(8'hA0);
        @(negedge clk);
        chk("stop bits", 16'h2, {14'h0, stopAfterByte, stopAtSeqEnd});
        cmdIn(6);
        chk("active", 16'h0, {15'h0, channelActive});
    endtask

    task automatic tTrigFall();
        wr(8'h18);
        wr(8'h58);
        cmdIn(3);
        triggerPin = 1'b0;
        cmdIn(8);
        chk("fall latency", 16'h4, first[15:0]);
        triggerPin = 1'b1;
        cmdIn(8);
        chk("rise ignored", 16'h0, hits[15:0]);
        wr(8'h80);
        @(negedge clk);
        chk("seq stop", 16'h1, {14'h0, stopAfterByte, stopAtSeqEnd});
        triggerPin = 1'b0;
        cmdIn(14);
        chk("active", 16'h0, {15'h0, channelActive});
    endtask

    task automatic tBusy();
        serialBusFree = 1'b0;
        wr(8'h40);
        chk("bus error", 16'h1, {15'h0, busError});
        chk("active", 16'h0, {15'h0, channelActive});
        serialBusFree = 1'b1;
    endtask

    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        rd(8'h00);
        tPtr();
        tGateOff();
        tTrigRise();
        tTrigFall();
        tBusy();
        results();
    end
endmodule

// file: src/ctrig_channel_control.sv
// Channel control register: trigger setup, pointer clears, start and stop requests.
// Assumes a synchronous parallel bus with one-cycle read and write strobes on clk,
// and a sequencer on clk that reports bus state, sequence end and STOP detection.
`timescale 1ns/1ps
`include "ctrig_consts.svh"

module ctrig_channel_control (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`CTRIG_ADDR_W-1:0] busAddr,
    input wire ctrig_pkg::ctrig_byte_t busWrData,
    input wire logic busWrite,
    input wire logic busRead,
    output ctrig_pkg::ctrig_byte_t busRdData,
    input wire logic triggerPin,
    input wire ctrig_pkg::ctrig_byte_t transactionSelect,
    input wire ctrig_pkg::ctrig_byte_t transactionOffset,
    input wire logic serialBusFree,
    input wire logic sequenceDone,
    input wire logic stopDetected,
    output logic startCmd,
    output logic busError,
    output logic channelActive,
    output logic stopAfterByte,
    output logic stopAtSeqEnd,
    output logic countPtrClear,
    output logic tablePtrClear,
    output ctrig_pkg::ctrig_ptr_t dataPtrValue
);
    import ctrig_pkg::*;

    ctrig_ctl_state_t st_q;
    ctrig_ctl_state_t st_d;
    ctrig_trig_if trig ();

    logic hit;
    logic wrCtl;
    logic wrStartIdle;
    logic fireOnTrigger;

    assign hit = (busAddr == `CTRIG_CHANNEL_CONTROL_OFS);
    assign wrCtl = busWrite && hit;
    assign wrStartIdle = wrCtl && !st_q.startReq && busWrData[`CTRIG_BIT_START];
    assign trig.edgeSel = st_q.edgeSel;

    // Arming lags start by the depth of the pin pipeline, so pin edges seen up to the
    // start write are lost and only later edges fire.
    assign fireOnTrigger = trig.trigEvent && st_q.gateOn && st_q.startReq
        && st_q.armed && !st_q.stopReq && !st_q.stopSeq;

    ctrig_trigger_detect u_detect (
        .clk(clk),
        .rst_n(rst_n),
        .triggerPin(triggerPin),
        .trig(trig)
    );

    always_comb begin
        st_d = st_q;
        st_d.startCmd = 1'b0;
        st_d.busError = 1'b0;
        st_d.countPtrClear = 1'b0;
        st_d.tablePtrClear = 1'b0;
        st_d.armDelay = {st_q.armDelay[0], st_q.startReq && st_q.gateOn};
        st_d.armed = st_q.armDelay[1];

        // Channel end clears the request bits before any host write is applied.
        if (stopDetected) begin
            st_d.stopReq = 1'b0;
            st_d.stopSeq = 1'b0;
            st_d.startReq = 1'b0;
            st_d.armDelay = 2'h0;
            st_d.armed = 1'b0;
        end else if (sequenceDone && !st_q.gateOn && !st_q.stopReq && !st_q.stopSeq) begin
            st_d.startReq = 1'b0;
            st_d.armDelay = 2'h0;
            st_d.armed = 1'b0;
        end

        if (wrCtl) begin
            if (!st_q.startReq) begin
                st_d.edgeSel = busWrData[`CTRIG_BIT_EDGE_SEL];
                st_d.gateOn = busWrData[`CTRIG_BIT_GATE_ON];
            end
            if (wrStartIdle) begin
                if (serialBusFree) begin
                    st_d.startReq = 1'b1;
                    // In trigger mode the write only arms; the pin paces START.
                    st_d.startCmd = !busWrData[`CTRIG_BIT_GATE_ON];
                end else begin
                    st_d.busError = 1'b1;
                end
            end
            // Stop bits are taken only on a running channel; setting wins over clearing.
            if (st_q.startReq) begin
                if (busWrData[`CTRIG_BIT_STOP]) begin
                    st_d.stopReq = 1'b1;
                    st_d.stopSeq = 1'b0;
                end else if (busWrData[`CTRIG_BIT_STOP_SEQ] && !st_q.stopReq) begin
                    st_d.stopSeq = 1'b1;
                end
            end
            st_d.countPtrClear = busWrData[`CTRIG_BIT_COUNT_PTR_CLR];
            if (busWrData[`CTRIG_BIT_TABLE_PTR_CLR]) begin
                st_d.tablePtrClear = 1'b1;
                st_d.dataPtrValue = {transactionSelect, transactionOffset};
            end
        end

        if (fireOnTrigger) begin
            st_d.startCmd = 1'b1;
        end

        // Strobe bits and the reserved bit always read back as zero.
        st_d.rdData = '0;
        if (busRead && hit) begin
            st_d.rdData[`CTRIG_BIT_STOP_SEQ] = st_q.stopSeq;
            st_d.rdData[`CTRIG_BIT_START] = st_q.startReq;
            st_d.rdData[`CTRIG_BIT_STOP] = st_q.stopReq;
            st_d.rdData[`CTRIG_BIT_EDGE_SEL] = st_q.edgeSel;
            st_d.rdData[`CTRIG_BIT_GATE_ON] = st_q.gateOn;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign busRdData = st_q.rdData;
    assign startCmd = st_q.startCmd;
    assign busError = st_q.busError;
    assign channelActive = st_q.startReq;
    assign stopAfterByte = st_q.stopReq;
    assign stopAtSeqEnd = st_q.stopSeq;
    assign countPtrClear = st_q.countPtrClear;
    assign tablePtrClear = st_q.tablePtrClear;
    assign dataPtrValue = st_q.dataPtrValue;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_EDGE_HOLD: assert property ($past(st_q.startReq) |-> $stable(st_q.edgeSel))
        else $error("Edge select changed while active.");

    AST_GATE_HOLD: assert property ($past(st_q.startReq) |-> $stable(st_q.gateOn))
        else $error("Trigger enable changed while active.");

    AST_TRIG_NO_DIRECT: assert property (wrStartIdle && serialBusFree
        && busWrData[`CTRIG_BIT_GATE_ON] |=> channelActive && !startCmd)
        else $error("Trigger mode start fired without a trigger.");

    AST_TRIG_START: assert property (fireOnTrigger |=> startCmd)
        else $error("Armed trigger did not issue START.");

    AST_TRIG_IGNORED: assert property (trig.trigEvent && !st_q.gateOn
        && !wrStartIdle |=> !startCmd)
        else $error("Trigger acted with trigger enable off.");

    AST_PTR_STROBES: assert property (wrCtl && busWrData[`CTRIG_BIT_COUNT_PTR_CLR]
        |=> countPtrClear)
        else $error("Count table pointer clear missing after write.");

    AST_COUNT_PULSE: assert property (countPtrClear |-> $past(wrCtl)
        && $past(busWrData[`CTRIG_BIT_COUNT_PTR_CLR]))
        else $error("Count table pointer clear without a write.");

    AST_TABLE_PTR: assert property (wrCtl && busWrData[`CTRIG_BIT_TABLE_PTR_CLR]
        |=> tablePtrClear
        && dataPtrValue == {$past(transactionSelect), $past(transactionOffset)})
        else $error("Table pointer clear or data pointer load wrong.");

    AST_READ_ZERO: assert property (busRead |=> busRdData[2:0] == 3'h0)
        else $error("Write-only bits read back nonzero.");

    AST_LATENCY: assert property ($rose(st_q.startReq) && st_q.gateOn
        |=> (!startCmd) [*3])
        else $error("Trigger coinciding with start was not ignored.");

    AST_STOP_IGNORED: assert property (wrCtl && !st_q.startReq |=> !stopAfterByte
        && !stopAtSeqEnd)
        else $error("Stop write took effect while idle.");

    AST_STOP_PRIO: assert property (stopAfterByte |-> !stopAtSeqEnd)
        else $error("Both stop requests pending.");

    AST_STOP_CLEAR: assert property (stopDetected && !wrCtl |=> !stopAfterByte
        && !stopAtSeqEnd && !channelActive)
        else $error("Stop bits not cleared on STOP detected.");

    AST_BUS_ERR: assert property (wrStartIdle && !serialBusFree
        |=> busError && !channelActive && !startCmd)
        else $error("Busy bus start not refused.");

    COV_DIRECT_START: cover property (wrStartIdle && serialBusFree ##1 startCmd);
    COV_TRIG_START: cover property (fireOnTrigger ##1 startCmd);
    COV_STOP: cover property (stopAfterByte ##[1:20] stopDetected);
    COV_BUS_ERR: cover property (busError);

endmodule

// file: src/ctrig_consts.svh
// Offsets, field positions and widths of the channel control register.
// Assumes inclusion from the package and the design files by bare name.
`ifndef CTRIG_CONSTS_SVH
`define CTRIG_CONSTS_SVH

`define CTRIG_ADDR_W 8
`define CTRIG_DATA_W 8
`define CTRIG_CHANNEL_CONTROL_OFS 8'hC0
`define CTRIG_CONTROL_RESET 8'h00
`define CTRIG_BIT_STOP_SEQ 7
`define CTRIG_BIT_START 6
`define CTRIG_BIT_STOP 5
`define CTRIG_BIT_EDGE_SEL 4
`define CTRIG_BIT_GATE_ON 3
`define CTRIG_BIT_COUNT_PTR_CLR 2
`define CTRIG_BIT_TABLE_PTR_CLR 1
`define CTRIG_PTR_W 16

`endif

// file: src/ctrig_pkg.sv
// Types shared by the trigger detector and the channel control register.
// Assumes the constants header is on the include path.
`include "ctrig_consts.svh"

package ctrig_pkg;

    typedef logic [`CTRIG_DATA_W-1:0] ctrig_byte_t;
    typedef logic [`CTRIG_PTR_W-1:0] ctrig_ptr_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic trigEvent;
    } ctrig_det_state_t;

    typedef struct packed {
        logic edgeSel;
        logic gateOn;
        logic startReq;
        logic stopReq;
        logic stopSeq;
        logic [1:0] armDelay;
        logic armed;
        logic startCmd;
        logic busError;
        logic countPtrClear;
        logic tablePtrClear;
        ctrig_ptr_t dataPtrValue;
        ctrig_byte_t rdData;
    } ctrig_ctl_state_t;

endpackage

// file: src/ctrig_trig_if.sv
// Carrier between the channel control register and its trigger detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface ctrig_trig_if;
    logic edgeSel;
    logic trigEvent;

    modport ctl (
        output edgeSel,
        input trigEvent
    );

    modport det (
        input edgeSel,
        output trigEvent
    );
endinterface

// file: src/ctrig_trigger_detect.sv
// Trigger pin synchroniser and selectable edge detector.
// Assumes the trigger pin is asynchronous to clk.
`timescale 1ns/1ps

module ctrig_trigger_detect (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic triggerPin,
    ctrig_trig_if.det trig
);
    import ctrig_pkg::*;

    ctrig_det_state_t st_q;
    ctrig_det_state_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.sync1 = triggerPin;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
        // Edge is judged on the second and third stage only.
        if (trig.edgeSel) begin
            st_d.trigEvent = st_q.prev & ~st_q.sync2;
        end else begin
            st_d.trigEvent = ~st_q.prev & st_q.sync2;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign trig.trigEvent = st_q.trigEvent;

    AST_EDGE_POLARITY: assert property (@(posedge clk) disable iff (!rst_n)
        st_q.trigEvent |-> ($past(trig.edgeSel) ? !$past(st_q.sync2) : $past(st_q.sync2)))
        else $error("Trigger event on wrong edge.");

endmodule

// file: src/ctrig_unused_placeholder_none.sv
// Intentionally empty design unit list terminator.
`timescale 1ns/1ps
